// *** core/core_pkg.sv ***
`default_nettype none
`include "cpu_core_cfg.svh"

package core_pkg;

    // Operations that the sequencer executes; anything else runs as a no-operation.
    typedef enum logic [3:0] {
        OP_NOP, OP_MOVLW, OP_RETURN_WITH_LITERAL_OP, OP_GOTO, OP_CALL, OP_ADDWF, OP_MOVF, OP_MOVWF,
        OP_BSF, OP_BCF, OP_BTFSS, OP_BTFSC, OP_RETURN_FROM_IRQ_OP, OP_RETURN
    } op_e;

    // The four phases of one instruction cycle.
    typedef enum logic [1:0] {PH_ONE, PH_TWO, PH_THREE, PH_FOUR} phase_e;

    // Operand fields split out of one instruction word.
    typedef struct packed {
        op_e op;
        logic dest;
        logic access;
        logic [7:0] freg;
        logic [2:0] bitsel;
        logic [7:0] lit;
        logic sflag;
        logic two_word;
    } insn_fields_s;

    // Classic Wishbone request and answer.
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_s;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wb_rsp_s;

endpackage

`default_nettype wire

// *** core/cpu_core_cfg.svh ***
`ifndef CPU_CORE_CFG_SVH
`define CPU_CORE_CFG_SVH

// ----------------------------------------------------------------
// Core sizing and instruction cycle
// ----------------------------------------------------------------
`define PC_W 20
`define STACK_DEPTH 8
`define Q_PER_CYCLE 4
`define STD_INSN_COUNT 8'h4B
`define EXT_INSN_COUNT 8'h08
`define NOP_WORD 16'h0000
`define SECOND_WORD_TAG 4'hF

// ----------------------------------------------------------------
// Opcode patterns, matched on the top 4 to 8 bits or the top 15 bits of the word
// ----------------------------------------------------------------
`define OPC_MOVLW 8'h0E
`define OPC_RETURN_WITH_LITERAL_OP 8'h0C
`define OPC_GOTO 8'hEF
`define OPC_CALL 7'h76
`define OPC_ADDWF 6'h09
`define OPC_MOVF 6'h14
`define OPC_MOVWF 7'h37
`define OPC_BSF 4'h8
`define OPC_BCF 4'h9
`define OPC_BTFSS 4'hA
`define OPC_BTFSC 4'hB
`define OPC_RETURN_FROM_IRQ_OP 15'h0008
`define OPC_RETURN 15'h0009

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_CORE_STAT 8'h04
`define OFS_WORK 8'h08
`define OFS_STATUS 8'h0C
`define OFS_BSR 8'h10
`define OFS_SH_WORK 8'h14
`define OFS_SH_STATUS 8'h18
`define OFS_SH_BSR 8'h1C
`define OFS_IRQ_EN 8'h20
`define OFS_PCLAT 8'h24
`define OFS_INFO 8'h28
`define OFS_STACK 8'h2C
`define OFS_CYCLES 8'h30
`define OFS_FADDR 8'h34
`define OFS_FDATA 8'h38

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define CTRL_RUN 0
`define CTRL_PRIO 1
`define IRQ_HIGH 0
`define IRQ_LOW 1
`define STATUS_C 0
`define STATUS_Z 2
`define RST_BYTE 8'h00
`define RST_PC 20'h0_0000

`endif

// *** core/cpu_instruction_decode_return.sv ***
// Implementation choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "cpu_core_cfg.svh"

// Summary of operation
// - Instructions are fetched as 16-bit words, and two kinds, goto and call, take two consecutive words.
// - Each word splits into an opcode that picks the operation and operand fields.
// - A byte operation writes the working register when d is 0, the file register when 1.
// - A bit operation picks its bit by the bit field inside the addressed file register.
// - A second word has its top four bits set and runs as a no-operation when alone.
// - A single-word instruction takes one cycle, or two when it skips or changes the PC.
// - Two-word instructions take two cycles, and a taken skip over one takes three.
// - One instruction cycle is four clock periods, the phases one to four.
// - The set holds 75 standard instructions and 8 extended ones.
// - Return from interrupt pops the stack into the PC and sets a global irq enable.
// - With its s bit at 1 it restores the shadow W, status and bank select; at 0 not.
// - It is one word and two cycles: decode in phase one, pop and enable in phase four.
// - Return with literal loads W with the literal and pops the PC, latches untouched.
// - It takes two cycles: literal read in phase two, pop and W write in phase four.

module cpu_instruction_decode_return (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire core_pkg::wb_req_s wb_req_i,
    output core_pkg::wb_rsp_s wb_rsp_o,
    output logic [19:0] pm_addr_o,
    input wire logic [15:0] pm_data_i,
    output core_pkg::phase_e phase_o
);
    import core_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic ctrl_run_r, ctrl_prio_r;
    logic [15:0] ir_r;
    logic [19:0] pc_r;
    logic [7:0] w_r, status_r, bsr_r;
    logic [7:0] sh_w_r, sh_status_r, sh_bsr_r;
    logic irq_hi_r, irq_lo_r;
    logic [7:0] pc_high_latch_r;
    logic [4:0] pc_upper_latch_r;
    logic [7:0] fval_r, lit_r, res_r;
    logic carry_r, skip_r;
    logic [31:0] cyc_cnt_r;
    logic [7:0] faddr_r;
    logic ack_r;
    logic [31:0] rdat_r;
    logic [3:0] sp_r;
    logic [19:0] stack_mem [`STACK_DEPTH];
    logic [7:0] dmem [256];

    phase_e phase;
    logic q4;
    insn_fields_s fld;

    // ----------------------------------------------------------------
    // Phase sequencing and field split
    // ----------------------------------------------------------------
    phase_seq u_phase (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .run_i(ctrl_run_r),
        .phase_o(phase),
        .q4_o(q4)
    );

    insn_split u_split (
        .word_i(ir_r),
        .fields_o(fld)
    );

    // ----------------------------------------------------------------
    // Execute decode
    // ----------------------------------------------------------------
    logic byte_op, bit_op, is_ret, rfi_s, flush, push, pop;
    logic [7:0] bit_mask, fval_rd, res_nxt;
    logic [8:0] sum;
    logic bit_val, skip_nxt;
    logic [19:0] target, stack_top, pc_inc, pc_nxt;
    logic [2:0] top_idx;

    // Operation classes.
    assign byte_op = (fld.op == OP_ADDWF) | (fld.op == OP_MOVF);
    assign bit_op = (fld.op == OP_BSF) | (fld.op == OP_BCF);
    assign is_ret = (fld.op == OP_RETURN) | (fld.op == OP_RETURN_FROM_IRQ_OP) | (fld.op == OP_RETURN_WITH_LITERAL_OP);
    assign rfi_s = (fld.op == OP_RETURN_FROM_IRQ_OP) & fld.sflag;

    // Data path of phases two and three.
    assign fval_rd = dmem[fld.freg];
    assign bit_mask = 8'h01 << fld.bitsel;
    assign bit_val = |(fval_r & bit_mask);
    assign sum = {1'b0, w_r} + {1'b0, fval_r};
    assign res_nxt = (fld.op == OP_ADDWF) ? sum[7:0] :
                     (fld.op == OP_BSF) ? (fval_r | bit_mask) :
                     (fld.op == OP_BCF) ? (fval_r & ~bit_mask) :
                     (fld.op == OP_MOVWF) ? w_r : fval_r;
    assign skip_nxt = ((fld.op == OP_BTFSC) & ~bit_val) | ((fld.op == OP_BTFSS) & bit_val);

    // Flow: the word fetched during a jump, return or taken skip is dropped.
    assign target = {pm_data_i[11:0], fld.lit};
    assign top_idx = 3'(sp_r - 4'h1);
    assign stack_top = stack_mem[top_idx];
    assign pc_inc = pc_r + 20'h0_0001;
    assign flush = fld.two_word | is_ret | skip_r;
    assign pc_nxt = fld.two_word ? target : (is_ret ? stack_top : pc_inc);
    assign push = q4 & (fld.op == OP_CALL) & (sp_r != 4'(`STACK_DEPTH));
    assign pop = q4 & is_ret & (sp_r != 4'h0);

    // ----------------------------------------------------------------
    // Register bus decode
    // ----------------------------------------------------------------
    logic hit, wr;
    logic wr_ctrl, wr_work, wr_status, wr_bsr, wr_sh_w, wr_sh_st, wr_sh_bsr;
    logic wr_irq, wr_pclat, wr_faddr, wr_fdata;
    logic [31:0] rd_mux;
    logic [7:0] adr;
    logic [7:0] wd;

    // One answer per request; writes land on lane zero, plus lane one for the upper latch.
    assign adr = wb_req_i.adr;
    assign wd = wb_req_i.dat[7:0];
    assign hit = wb_req_i.cyc & wb_req_i.stb & ~ack_r;
    assign wr = hit & wb_req_i.we & wb_req_i.sel[0];
    assign wr_ctrl = wr & (adr == `OFS_CTRL);
    assign wr_work = wr & (adr == `OFS_WORK);
    assign wr_status = wr & (adr == `OFS_STATUS);
    assign wr_bsr = wr & (adr == `OFS_BSR);
    assign wr_sh_w = wr & (adr == `OFS_SH_WORK);
    assign wr_sh_st = wr & (adr == `OFS_SH_STATUS);
    assign wr_sh_bsr = wr & (adr == `OFS_SH_BSR);
    assign wr_irq = wr & (adr == `OFS_IRQ_EN);
    assign wr_pclat = hit & wb_req_i.we & (adr == `OFS_PCLAT);
    assign wr_faddr = wr & (adr == `OFS_FADDR);
    assign wr_fdata = wr & (adr == `OFS_FDATA);

    // Read selection; unmapped offsets answer with zero.
    assign rd_mux = (adr == `OFS_CTRL) ? {30'h0, ctrl_prio_r, ctrl_run_r} :
                    (adr == `OFS_CORE_STAT) ? {10'h0, phase, pc_r} :
                    (adr == `OFS_WORK) ? {24'h0, w_r} :
                    (adr == `OFS_STATUS) ? {24'h0, status_r} :
                    (adr == `OFS_BSR) ? {24'h0, bsr_r} :
                    (adr == `OFS_SH_WORK) ? {24'h0, sh_w_r} :
                    (adr == `OFS_SH_STATUS) ? {24'h0, sh_status_r} :
                    (adr == `OFS_SH_BSR) ? {24'h0, sh_bsr_r} :
                    (adr == `OFS_IRQ_EN) ? {30'h0, irq_lo_r, irq_hi_r} :
                    (adr == `OFS_PCLAT) ? {19'h0, pc_upper_latch_r, pc_high_latch_r} :
                    (adr == `OFS_INFO) ? {16'h0, `EXT_INSN_COUNT, `STD_INSN_COUNT} :
                    (adr == `OFS_STACK) ? {28'h0, sp_r} :
                    (adr == `OFS_CYCLES) ? cyc_cnt_r :
                    (adr == `OFS_FADDR) ? {24'h0, faddr_r} :
                    (adr == `OFS_FDATA) ? {24'h0, dmem[faddr_r]} : 32'h0000_0000;

    assign wb_rsp_o.ack = ack_r;
    assign wb_rsp_o.dat = rdat_r;
    assign pm_addr_o = pc_r;
    assign phase_o = phase;

    // ----------------------------------------------------------------
    // Bus answer and control
    // ----------------------------------------------------------------
    // Acknowledge one cycle after the request, with registered read data.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            ack_r <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end else begin
            ack_r <= hit;
            rdat_r <= hit ? rd_mux : rdat_r;
        end
    end

    // Run control, file window pointer and address latches.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            ctrl_run_r <= 1'b0;
            ctrl_prio_r <= 1'b0;
            faddr_r <= `RST_BYTE;
            pc_high_latch_r <= `RST_BYTE;
            pc_upper_latch_r <= 5'h00;
        end else begin
            if (wr_ctrl) begin
                ctrl_run_r <= wd[`CTRL_RUN];
                ctrl_prio_r <= wd[`CTRL_PRIO];
            end
            if (wr_faddr) begin
                faddr_r <= wd;
            end
            // Return with literal never touches these latches.
            if (wr_pclat & wb_req_i.sel[0]) begin
                pc_high_latch_r <= wd;
            end
            if (wr_pclat & wb_req_i.sel[1]) begin
                pc_upper_latch_r <= wb_req_i.dat[12:8];
            end
        end
    end

    // ----------------------------------------------------------------
    // Instruction pipeline
    // ----------------------------------------------------------------
    // Phase two reads the operand and the literal; phase three computes the result.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            fval_r <= `RST_BYTE;
            lit_r <= `RST_BYTE;
            res_r <= `RST_BYTE;
            carry_r <= 1'b0;
            skip_r <= 1'b0;
        end else begin
            if (phase == PH_TWO) begin
                fval_r <= fval_rd;
                lit_r <= fld.lit;
            end
            if (phase == PH_THREE) begin
                res_r <= res_nxt;
                carry_r <= sum[8];
                skip_r <= skip_nxt;
            end
            if (q4) begin
                skip_r <= 1'b0;
            end
        end
    end

    // Fetch at the end of phase four; a flushed slot runs as a no-operation cycle.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            ir_r <= `NOP_WORD;
            pc_r <= `RST_PC;
            cyc_cnt_r <= 32'h0000_0000;
        end else if (q4) begin
            ir_r <= flush ? `NOP_WORD : pm_data_i;
            pc_r <= pc_nxt;
            cyc_cnt_r <= cyc_cnt_r + 32'h0000_0001;
        end
    end

    // Return stack: calls push the address after their second word.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            sp_r <= 4'h0;
        end else if (push) begin
            stack_mem[sp_r[2:0]] <= pc_inc;
            sp_r <= sp_r + 4'h1;
        end else if (pop) begin
            sp_r <= sp_r - 4'h1;
        end
    end

    // ----------------------------------------------------------------
    // Architectural registers
    // ----------------------------------------------------------------
    // Working register; core writes in phase four win over the bus.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            w_r <= `RST_BYTE;
        end else if (q4 & rfi_s) begin
            w_r <= sh_w_r;
        end else if (q4 & ((fld.op == OP_RETURN_WITH_LITERAL_OP) | (fld.op == OP_MOVLW))) begin
            w_r <= lit_r;
        end else if (q4 & byte_op & ~fld.dest) begin
            w_r <= res_r;
        end else if (wr_work) begin
            w_r <= wd;
        end
    end

    // Status and bank select, restored from shadows by a return with s set.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            status_r <= `RST_BYTE;
            bsr_r <= `RST_BYTE;
        end else begin
            if (q4 & rfi_s) begin
                status_r <= sh_status_r;
            end else if (q4 & byte_op) begin
                status_r[`STATUS_Z] <= (res_r == 8'h00);
                status_r[`STATUS_C] <= (fld.op == OP_ADDWF) ? carry_r : status_r[`STATUS_C];
            end else if (wr_status) begin
                status_r <= wd;
            end
            if (q4 & rfi_s) begin
                bsr_r <= sh_bsr_r;
            end else if (wr_bsr) begin
                bsr_r <= wd;
            end
        end
    end

    // Shadow copies: a fast call saves them, software may also load them.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            sh_w_r <= `RST_BYTE;
            sh_status_r <= `RST_BYTE;
            sh_bsr_r <= `RST_BYTE;
        end else if (q4 & (fld.op == OP_CALL) & fld.sflag) begin
            sh_w_r <= w_r;
            sh_status_r <= status_r;
            sh_bsr_r <= bsr_r;
        end else begin
            sh_w_r <= wr_sh_w ? wd : sh_w_r;
            sh_status_r <= wr_sh_st ? wd : sh_status_r;
            sh_bsr_r <= wr_sh_bsr ? wd : sh_bsr_r;
        end
    end

    // Interrupt enables: the return sets the high one unless priorities are on and it is set.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            irq_hi_r <= 1'b0;
            irq_lo_r <= 1'b0;
        end else if (q4 & (fld.op == OP_RETURN_FROM_IRQ_OP)) begin
            irq_hi_r <= (~ctrl_prio_r | ~irq_hi_r) ? 1'b1 : irq_hi_r;
            irq_lo_r <= (ctrl_prio_r & irq_hi_r) ? 1'b1 : irq_lo_r;
        end else if (wr_irq) begin
            irq_hi_r <= wd[`IRQ_HIGH];
            irq_lo_r <= wd[`IRQ_LOW];
        end
    end

    // File registers: phase-four writeback wins over the bus window.
    always_ff @(posedge sys_clk_i) begin
        if (q4 & ((byte_op & fld.dest) | (fld.op == OP_MOVWF) | bit_op)) begin
            dmem[fld.freg] <= res_r;
        end else if (wr_fdata) begin
            dmem[faddr_r] <= wd;
        end
    end
endmodule // cpu_instruction_decode_return

`default_nettype wire

// *** core/insn_split.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "cpu_core_cfg.svh"

module insn_split (
    input wire logic [15:0] word_i,
    output core_pkg::insn_fields_s fields_o
);
    import core_pkg::*;

    logic [7:0] hi;
    op_e op;

    // A lone second word carries the tag nibble and falls through to a no-operation.
    assign hi = word_i[15:8];
    assign op = (word_i[15:12] == `SECOND_WORD_TAG) ? OP_NOP :
                (hi == `OPC_MOVLW) ? OP_MOVLW :
                (hi == `OPC_RETURN_WITH_LITERAL_OP) ? OP_RETURN_WITH_LITERAL_OP :
                (hi == `OPC_GOTO) ? OP_GOTO :
                (hi[7:1] == `OPC_CALL) ? OP_CALL :
                (hi[7:2] == `OPC_ADDWF) ? OP_ADDWF :
                (hi[7:2] == `OPC_MOVF) ? OP_MOVF :
                (hi[7:1] == `OPC_MOVWF) ? OP_MOVWF :
                (hi[7:4] == `OPC_BSF) ? OP_BSF :
                (hi[7:4] == `OPC_BCF) ? OP_BCF :
                (hi[7:4] == `OPC_BTFSS) ? OP_BTFSS :
                (hi[7:4] == `OPC_BTFSC) ? OP_BTFSC :
                (word_i[15:1] == `OPC_RETURN_FROM_IRQ_OP) ? OP_RETURN_FROM_IRQ_OP :
                (word_i[15:1] == `OPC_RETURN) ? OP_RETURN : OP_NOP;

    // Operand fields sit at fixed positions for every format, except s: bit 8 for call, bit 0 otherwise.
    assign fields_o.op = op;
    assign fields_o.dest = word_i[9];
    assign fields_o.access = word_i[8];
    assign fields_o.freg = word_i[7:0];
    assign fields_o.bitsel = word_i[11:9];
    assign fields_o.lit = word_i[7:0];
    assign fields_o.sflag = (op == OP_CALL) ? word_i[8] : word_i[0];
    assign fields_o.two_word = (op == OP_GOTO) | (op == OP_CALL);
endmodule // insn_split

`default_nettype wire

// *** core/phase_seq.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "cpu_core_cfg.svh"

module phase_seq (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic run_i,
    output core_pkg::phase_e phase_o,
    output logic q4_o
);
    import core_pkg::*;

    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;
    logic advance;

    // A started cycle always completes; a new one starts only while running.
    assign advance = run_i | (cnt_r != 2'h0);
    assign cnt_nxt = (cnt_r == 2'(`Q_PER_CYCLE - 1)) ? 2'h0 : cnt_r + 2'h1;
    assign phase_o = phase_e'(cnt_r);
    assign q4_o = (cnt_r == 2'(`Q_PER_CYCLE - 1));

    // Phase counter.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            cnt_r <= 2'h0;
        end else if (advance) begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule // phase_seq

`default_nettype wire

// *** dv/decode_checker_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "cpu_core_cfg.svh"

module decode_checker (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire core_pkg::wb_req_s wb_req_i,
    input wire core_pkg::wb_rsp_s wb_rsp_o,
    input wire logic [19:0] pm_addr_o,
    input wire logic [15:0] pm_data_i,
    input wire core_pkg::phase_e phase_o
);
    import core_pkg::*;

    // ----------------------------------------------------------------
    // Port relations
    // ----------------------------------------------------------------

    // A request is open while cycle and strobe are both high.
    wire logic req_open;
    wire logic rd_ack;
    assign req_open = wb_req_i.cyc && wb_req_i.stb;
    assign rd_ack = wb_rsp_o.ack && !wb_req_i.we;

    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (srst_i);

    // Once phase two is reached the rest of the cycle follows in order.
    sequence s_cycle_tail;
        phase_o == PH_THREE ##1 phase_o == PH_FOUR ##1 phase_o == PH_ONE;
    endsequence

    a_ack_one_pulse: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
        else $error("ack stayed high a second cycle");
    a_ack_next_cycle: assert property (req_open && !wb_rsp_o.ack |=> wb_rsp_o.ack)
        else $error("request not answered in the next cycle");
    a_ack_has_cause: assert property (wb_rsp_o.ack |-> $past(req_open))
        else $error("ack without a request");
    a_phase_in_order: assert property (
        $changed(phase_o) |-> phase_o == phase_e'($past(phase_o) + 2'd1))
        else $error("phase skipped or went back");
    a_cycle_runs_out: assert property (phase_o == PH_TWO |=> s_cycle_tail)
        else $error("instruction cycle did not finish");
    a_fetch_at_four: assert property (
        $changed(pm_addr_o) |-> $past(phase_o) == PH_FOUR)
        else $error("fetch address moved outside phase four");
    a_info_counts: assert property (
        rd_ack && wb_req_i.adr == `OFS_INFO
        |-> wb_rsp_o.dat == {16'h0000, `EXT_INSN_COUNT, `STD_INSN_COUNT})
        else $error("instruction set counts wrong");
    a_unmapped_zero: assert property (rd_ack && wb_req_i.adr == 8'h3C |-> wb_rsp_o.dat == '0)
        else $error("unmapped read not zero");

endmodule // decode_checker

bind cpu_instruction_decode_return decode_checker u_decode_checker (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .wb_req_i(wb_req_i),
    .wb_rsp_o(wb_rsp_o),
    .pm_addr_o(pm_addr_o),
    .pm_data_i(pm_data_i),
    .phase_o(phase_o)
);

`default_nettype wire

// *** dv/prog_mem_model.sv ***
`timescale 1ns/1ns
`default_nettype none

module prog_mem_model (
    input wire logic sys_clk_i,
    input wire logic [19:0] pm_addr_i,
    input wire logic [1:0] lat_i,
    output logic [15:0] pm_data_o
);
    // ----------------------------------------------------------------
    // Program store with a selectable access time
    // ----------------------------------------------------------------
    logic [15:0] mem [0:63];
    logic [19:0] last_r = 20'h0_0000;
    logic [1:0] age_r = 2'h0;
    logic [15:0] junk_r = 16'h5A5A;
    wire logic fresh;

    // Age counts how long the address has stood; stale output flips every cycle.
    always @(posedge sys_clk_i) begin
        last_r <= pm_addr_i;
        junk_r <= ~junk_r;
        age_r <= (pm_addr_i != last_r) ? 2'd0 : ((age_r == 2'd3) ? 2'd3 : age_r + 2'd1);
    end

    // A whole 16-bit word is shown only once the access time has passed.
    assign fresh = (lat_i == 2'd0) || (pm_addr_i == last_r && age_r >= lat_i - 2'd1);
    assign pm_data_o = fresh ? mem[pm_addr_i[5:0]] : junk_r;

endmodule // prog_mem_model

`default_nettype wire

// *** dv/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "cpu_core_cfg.svh"

module tb;
    import core_pkg::*;

    // ----------------------------------------------------------------
    // Harness
    // ----------------------------------------------------------------
    logic sys_clk_i;
    logic srst_i;
    wb_req_s req;
    wb_rsp_s rsp;
    logic [19:0] pm_addr;
    logic [15:0] pm_data;
    phase_e phase;
    logic [1:0] lat;
    logic [31:0] rd;
    int mismatches = 0;
    int cmp_count = 0;
    int edges = 0;

    cpu_instruction_decode_return u_cpu_instruction_decode_return (
        .sys_clk_i(sys_clk_i), .srst_i(srst_i), .wb_req_i(req), .wb_rsp_o(rsp),
        .pm_addr_o(pm_addr), .pm_data_i(pm_data), .phase_o(phase));
    prog_mem_model u_prog_mem_model (
        .sys_clk_i(sys_clk_i), .pm_addr_i(pm_addr), .lat_i(lat), .pm_data_o(pm_data));

    initial begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    // Counts phase-four edges, each the close of one instruction cycle.
    always @(posedge sys_clk_i) begin
        if (phase === PH_FOUR) begin
            edges <= edges + 1;
        end
    end

    // Cycles from run to the last return: fill, program body, return itself.
    function automatic int exp_edges();
        int cost[10] = '{1, 1, 1, 1, 1, 2, 3, 2, 2, 2};
        exp_edges = 2 + cost.sum();
    endfunction

    // A return with restore takes the shadow copy, otherwise the live value stays.
    function automatic logic [31:0] after_ret(input logic s, input logic [31:0] sh,
                                             input logic [31:0] live);
        after_ret = s ? sh : live;
    endfunction

    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (rsp.ack !== 1'b1 && n < 100);
        rd = rsp.dat;
        req <= '0;
        if (n >= 100) begin
            mismatches++;
        end
    endtask

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rchk(input string what, input logic [7:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, 32'h0000_0000);
        cmp(what, exp, rd);
    endtask

    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Two passes need well under a thousand cycles each; 40 us leaves headroom.
    initial begin
        #40000;
        mismatches++;
        close_out();
    end

    // ----------------------------------------------------------------
    // Scenarios: one program per pass, restore off then on
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] k, k2, f, g, gi, b, shw, shb, bank, pcl;
        logic s;
        int n;
        logic [15:0] prog [16];
        srst_i = 1'b1;
        req = '0;
        lat = 2'd0;
        rd = $urandom(32'h0000_e848);
        for (int it = 0; it < 2; it++) begin
            srst_i <= 1'b1;
            lat <= 2'($urandom_range(3, 0));
            repeat (4) @(posedge sys_clk_i);
            srst_i <= 1'b0;
            k = $urandom_range(255, 0);
            k2 = $urandom_range(255, 0);
            f = $urandom_range(127, 0);
            g = f | 32'h0000_0080;
            gi = $urandom_range(255, 0);
            b = $urandom_range(7, 0);
            shw = $urandom_range(255, 0);
            shb = $urandom_range(15, 0);
            bank = $urandom_range(15, 0);
            pcl = $urandom_range(8191, 0);
            s = (it == 1);
            prog = '{{8'h0E, k[7:0]}, {8'h6E, f[7:0]}, {8'h24, f[7:0]}, {8'h26, f[7:0]},
                {4'h8, b[2:0], 1'b0, g[7:0]}, {4'hA, b[2:0], 1'b0, g[7:0]}, 16'h0EAA,
                {4'hA, b[2:0], 1'b0, g[7:0]}, 16'hEF00, 16'hF000, 16'hEC20, 16'hF000,
                16'hEC30, 16'hF000, 16'hEF0E, 16'hF000};
            for (int i = 0; i < 64; i++) begin
                u_prog_mem_model.mem[i] = (i < 16) ? prog[i] : `NOP_WORD;
            end
            u_prog_mem_model.mem[32] = {8'h0C, k2[7:0]};
            u_prog_mem_model.mem[48] = {15'h0008, s};
            rchk("info", `OFS_INFO, {16'h0000, `EXT_INSN_COUNT, `STD_INSN_COUNT});
            rchk("control at reset", `OFS_CTRL, 32'h0000_0000);
            wb(1'b1, 8'h3C, 32'hFFFF_FFFF);
            rchk("unmapped", 8'h3C, 32'h0000_0000);
            wb(1'b1, `OFS_FADDR, g);
            wb(1'b1, `OFS_FDATA, gi);
            wb(1'b1, `OFS_SH_WORK, shw);
            wb(1'b1, 8'h1C, shb);
            wb(1'b1, 8'h10, bank);
            wb(1'b1, `OFS_PCLAT, pcl);
            wb(1'b1, `OFS_IRQ_EN, {31'h0, s}); // Second pass starts with the high enable set.
            n = edges;
            wb(1'b1, `OFS_CTRL, {30'h0, s, 1'b1}); // Second pass runs in priority mode.
            for (int t = 0; t < 400 && pm_addr !== 20'h0_000E; t++) begin
                @(posedge sys_clk_i);
            end
            n = edges - n;
            cmp("cycles", 32'(exp_edges()), 32'(n));
            rchk("working", `OFS_WORK, after_ret(s, shw, k2));
            rchk("bank", 8'h10, after_ret(s, shb, bank));
            rchk("irq enable", `OFS_IRQ_EN, {30'h0, s, 1'b1});
            rchk("stack depth", `OFS_STACK, 32'h0000_0000);
            rchk("pc latches", `OFS_PCLAT, pcl);
            wb(1'b1, `OFS_FADDR, f);
            rchk("byte result", `OFS_FDATA, (3 * k) & 32'h0000_00FF);
            wb(1'b1, `OFS_FADDR, g);
            rchk("bit result", `OFS_FDATA, gi | (32'h0000_0001 << b));
        end
        close_out();
    end

endmodule // tb

`default_nettype wire
